// ===== logic/cpx_port.v
// Processor-side coprocessor handshake with AXI4-Lite control registers.
`timescale 1ns/1ps
`include "cpx_defines.vh"

////////////////////////////////////////////////////////////////////////////
module cpx_port (
   // Clock and reset
   input  wire        aclk,
   input  wire        aresetn,
   // AXI4-Lite write channels
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // AXI4-Lite read channels
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // Coprocessor handshake pins
   output reg         coproc_instr_strobe_n,
   input  wire        coproc_absent_n,
   input  wire        coproc_wait_n,
   output reg         user_mode_indicator_n,
   // Memory and data bus pins
   output reg         memory_request_n,
   output reg         burst_cycle_flag,
   output reg  [31:0] cp_address,
   input  wire        data_bus_enable_in,
   input  wire [31:0] data_in,
   output reg  [31:0] data_out,
   output reg         data_oe
);

   function [1:0] cpx_class;
      input [31:0] ins;
      begin
         if (!ins[`CPX_BIT_CLASS])
            cpx_class = `CPX_CL_UNDEF;
         else if (ins[27:25] == 3'h6)
            cpx_class = `CPX_CL_DATA;
         else if (ins[27:24] == 4'he)
            cpx_class = ins[`CPX_BIT_RT] ? `CPX_CL_REG : `CPX_CL_OP;
         else
            cpx_class = `CPX_CL_UNDEF;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; the handshake is therefore seen two edges late.
   reg [1:0]  absent_sync;
   reg [1:0]  wait_sync;
   reg [1:0]  dbe_sync;
   reg [31:0] data_sync0;
   reg [31:0] data_sync1;

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         absent_sync <= 2'h3;
         wait_sync   <= 2'h3;
         dbe_sync    <= 2'h0;
         data_sync0  <= 32'h00000000;
         data_sync1  <= 32'h00000000;
      end
      else
      begin
         absent_sync <= {absent_sync[0], coproc_absent_n};
         wait_sync   <= {wait_sync[0], coproc_wait_n};
         dbe_sync    <= {dbe_sync[0], data_bus_enable_in};
         data_sync0  <= data_in;
         data_sync1  <= data_sync0;
      end
   end

   wire absent_s = absent_sync[1];
   wire wait_s   = wait_sync[1];
   wire dbe_s    = dbe_sync[1];

   ////////////////////////////////////////////////////////////////////////
   // Registers and state.
   reg [31:0] instr;
   reg        cond_pass;
   reg        user_mode;
   reg        irq_pend;
   reg [31:0] base_addr;
   reg [31:0] tx_data;
   reg [2:0]  state;
   reg [3:0]  absent_cnt;
   reg [7:0]  word_cnt;
   reg        undef_flag;
   reg        done_flag;
   reg        intr_flag;
   reg [7:0]  aw_addr;
   reg        aw_full;
   reg [31:0] w_data;
   reg [3:0]  w_strb;
   reg        w_full;

   wire        load_bit = instr[`CPX_BIT_LOAD];
   wire        buf_in_ready;
   wire        buf_out_valid;
   wire [31:0] buf_out_data;
   wire        do_write = aw_full & w_full & ~s_axi_bvalid;
   wire        ar_hs    = s_axi_arvalid & s_axi_arready;
   wire        pop_rx   = ar_hs & (s_axi_araddr == `CPX_OFF_RXDATA);
   wire        push_rx  = (state == `CPX_S_RTX) & load_bit;
   wire        issue    = do_write & (aw_addr == `CPX_OFF_CTRL) &
                          w_strb[0] & w_data[`CPX_CTRL_ISSUE] &
                          (state == `CPX_S_IDLE);
   // An MRC is held off until the buffer has room for its result.
   wire        room_ok  = ~((cpx_class(instr) == `CPX_CL_REG) & load_bit) |
                          buf_in_ready;

   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0]  strb;
      integer i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1)
            if (strb[i])
               merge[i*8 +: 8] = nw[i*8 +: 8];
      end
   endfunction

   cpx_buf2 #(
      .WIDTH(32)
   ) u_rx_buf (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .in_valid  (push_rx),
      .in_ready  (buf_in_ready),
      .in_data   (data_sync1),
      .out_valid (buf_out_valid),
      .out_ready (pop_rx),
      .out_data  (buf_out_data)
   );

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave; address and data may arrive in either order.
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `CPX_RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rresp   <= `CPX_RESP_OKAY;
         s_axi_rdata   <= 32'h00000000;
         aw_full       <= 1'b0;
         w_full        <= 1'b0;
         aw_addr       <= 8'h00;
         w_data        <= 32'h00000000;
         w_strb        <= 4'h0;
         instr         <= 32'h00000000;
         cond_pass     <= 1'b0;
         user_mode     <= 1'b0;
         irq_pend      <= 1'b0;
         base_addr     <= 32'h00000000;
         tx_data       <= 32'h00000000;
      end
      else
      begin
         s_axi_awready <= ~aw_full & ~(s_axi_awvalid & s_axi_awready);
         s_axi_wready  <= ~w_full & ~(s_axi_wvalid & s_axi_wready);
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_addr <= s_axi_awaddr;
            aw_full <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            w_full <= 1'b1;
         end
         if (do_write)
         begin
            aw_full      <= 1'b0;
            w_full       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= `CPX_RESP_OKAY;
            case (aw_addr)
               `CPX_OFF_INSTR:  instr     <= merge(instr, w_data, w_strb);
               `CPX_OFF_ADDR:   base_addr <= merge(base_addr, w_data, w_strb);
               `CPX_OFF_TXDATA: tx_data   <= merge(tx_data, w_data, w_strb);
               `CPX_OFF_CTRL:
               begin
                  if (w_strb[0])
                  begin
                     cond_pass <= w_data[`CPX_CTRL_COND];
                     user_mode <= w_data[`CPX_CTRL_USER];
                     irq_pend  <= w_data[`CPX_CTRL_IRQ];
                  end
               end
               default: s_axi_bresp <= `CPX_RESP_SLVERR;
            endcase
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;

         s_axi_arready <= ~s_axi_rvalid & ~ar_hs;
         if (ar_hs)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `CPX_RESP_OKAY;
            case (s_axi_araddr)
               `CPX_OFF_INSTR:  s_axi_rdata <= instr;
               `CPX_OFF_CTRL:   s_axi_rdata <= {28'h0000000, irq_pend,
                                                user_mode, cond_pass, 1'b0};
               `CPX_OFF_ADDR:   s_axi_rdata <= base_addr;
               `CPX_OFF_TXDATA: s_axi_rdata <= tx_data;
               `CPX_OFF_RXDATA: s_axi_rdata <= buf_out_valid ?
                                               buf_out_data : 32'h00000000;
               `CPX_OFF_STATUS: s_axi_rdata <= {16'h0000, word_cnt,
                                   buf_out_valid, intr_flag, done_flag,
                                   undef_flag, (state != `CPX_S_IDLE), state};
               default:
               begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= `CPX_RESP_SLVERR;
               end
            endcase
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Handshake sequencer.
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state                 <= `CPX_S_IDLE;
         coproc_instr_strobe_n <= 1'b1;
         user_mode_indicator_n <= 1'b1;
         memory_request_n      <= 1'b1;
         burst_cycle_flag      <= 1'b0;
         cp_address            <= 32'h00000000;
         data_out              <= 32'h00000000;
         data_oe               <= 1'b0;
         absent_cnt            <= 4'h0;
         word_cnt              <= 8'h00;
         undef_flag            <= 1'b0;
         done_flag             <= 1'b0;
         intr_flag             <= 1'b0;
      end
      else
      begin
         // An issuing write shows its mode together with the strobe, so a
         // coprocessor never judges privilege against the previous mode.
         user_mode_indicator_n <= issue ? ~w_data[`CPX_CTRL_USER] :
                                          ~user_mode;
         data_out              <= tx_data;
         case (state)
            `CPX_S_IDLE:
            begin
               if (issue)
               begin
                  undef_flag <= 1'b0;
                  intr_flag  <= 1'b0;
                  word_cnt   <= 8'h00;
                  absent_cnt <= 4'h0;
                  // The condition travels in the issuing write itself.
                  done_flag  <= ~w_data[`CPX_CTRL_COND];
                  if (w_data[`CPX_CTRL_COND] && room_ok)
                  begin
                     coproc_instr_strobe_n <= 1'b0;
                     state                 <= `CPX_S_WAIT;
                  end
                  else if (w_data[`CPX_CTRL_COND])
                     state <= `CPX_S_HOLD;
               end
            end
            `CPX_S_WAIT:
            begin
               if (irq_pend)
               begin
                  coproc_instr_strobe_n <= 1'b1;
                  intr_flag             <= 1'b1;
                  state                 <= `CPX_S_HOLD;
               end
               else if (!absent_s && !wait_s)
               begin
                  case (cpx_class(instr))
                     `CPX_CL_DATA:
                     begin
                        cp_address       <= base_addr;
                        memory_request_n <= 1'b0;
                        burst_cycle_flag <= 1'b0;
                        state            <= `CPX_S_XFER;
                     end
                     `CPX_CL_REG:
                     begin
                        memory_request_n <= 1'b1;
                        burst_cycle_flag <= 1'b1;
                        state            <= `CPX_S_RT;
                     end
                     default:
                     begin
                        coproc_instr_strobe_n <= 1'b1;
                        done_flag             <= 1'b1;
                        state                 <= `CPX_S_IDLE;
                     end
                  endcase
               end
               else if (absent_s && wait_s)
               begin
                  // Nobody claimed the instruction within the window.
                  if (absent_cnt == `CPX_ABSENT_CYC)
                  begin
                     coproc_instr_strobe_n <= 1'b1;
                     undef_flag            <= 1'b1;
                     state                 <= `CPX_S_IDLE;
                  end
                  else
                     absent_cnt <= absent_cnt + 4'h1;
               end
            end
            `CPX_S_HOLD:
            begin
               if (!irq_pend && room_ok)
               begin
                  coproc_instr_strobe_n <= 1'b0;
                  absent_cnt            <= 4'h0;
                  state                 <= `CPX_S_WAIT;
               end
            end
            `CPX_S_XFER:
            begin
               // Interrupt requests are not looked at in this state.
               if (absent_s && wait_s)
               begin
                  coproc_instr_strobe_n <= 1'b1;
                  memory_request_n      <= 1'b1;
                  burst_cycle_flag      <= 1'b0;
                  done_flag             <= 1'b1;
                  state                 <= `CPX_S_IDLE;
               end
               else
               begin
                  cp_address       <= cp_address + `CPX_WORD_STEP;
                  burst_cycle_flag <= 1'b1;
                  word_cnt         <= word_cnt + 8'h01;
               end
            end
            `CPX_S_RT:
            begin
               if (dbe_s)
               begin
                  data_oe <= ~load_bit;
                  state   <= `CPX_S_RTX;
               end
            end
            `CPX_S_RTX:
            begin
               data_oe               <= 1'b0;
               coproc_instr_strobe_n <= 1'b1;
               burst_cycle_flag      <= 1'b0;
               word_cnt              <= 8'h01;
               done_flag             <= 1'b1;
               state                 <= `CPX_S_IDLE;
            end
            default: state <= `CPX_S_IDLE;
         endcase
      end
   end

endmodule // cpx_port

// ===== logic/cpx_defines.vh
// Register map, field positions, state codes and timing counts.
`ifndef CPX_DEFINES_VH
`define CPX_DEFINES_VH

`define CPX_OFF_INSTR      8'h00
`define CPX_OFF_CTRL       8'h04
`define CPX_OFF_ADDR       8'h08
`define CPX_OFF_TXDATA     8'h0c
`define CPX_OFF_RXDATA     8'h10
`define CPX_OFF_STATUS     8'h14

`define CPX_CTRL_ISSUE     0
`define CPX_CTRL_COND      1
`define CPX_CTRL_USER      2
`define CPX_CTRL_IRQ       3

`define CPX_ST_BUSY        3
`define CPX_ST_UNDEF       4
`define CPX_ST_DONE        5
`define CPX_ST_INTR        6
`define CPX_ST_RXV         7

`define CPX_BIT_CLASS      27
`define CPX_BIT_LOAD       20
`define CPX_BIT_RT         4

`define CPX_CL_UNDEF       2'h0
`define CPX_CL_DATA        2'h1
`define CPX_CL_OP          2'h2
`define CPX_CL_REG         2'h3

`define CPX_S_IDLE         3'h0
`define CPX_S_WAIT         3'h1
`define CPX_S_XFER         3'h2
`define CPX_S_RT           3'h3
`define CPX_S_HOLD         3'h4
`define CPX_S_RTX          3'h5

`define CPX_ABSENT_CYC     4'h4
`define CPX_WORD_STEP      32'h00000004
`define CPX_RESP_OKAY      2'h0
`define CPX_RESP_SLVERR    2'h2

`endif

// ===== logic/cpx_buf2.v
// Two-entry valid/ready buffer for words taken from the coprocessor.
`timescale 1ns/1ps
module cpx_buf2 #(
   parameter WIDTH = 32
) (
   // Clock and reset
   input  wire             aclk,
   input  wire             aresetn,
   // Fill side
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   // Drain side
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data
);

   reg [WIDTH-1:0] mem [0:1];
   reg             wr_ptr;
   reg             rd_ptr;
   reg [1:0]       fill;

   wire push = in_valid & in_ready;
   wire pop  = out_valid & out_ready;

   assign in_ready  = (fill != 2'h2);
   assign out_valid = (fill != 2'h0);
   assign out_data  = mem[rd_ptr];

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         fill   <= 2'h0;
      end
      else
      begin
         if (push)
         begin
            mem[wr_ptr] <= in_data;
            wr_ptr      <= ~wr_ptr;
         end
         if (pop)
            rd_ptr <= ~rd_ptr;
         if (push && !pop)
            fill <= fill + 2'h1;
         else if (pop && !push)
            fill <= fill - 2'h1;
      end
   end

endmodule // cpx_buf2

// ===== testbench/cpx_port_assertions.sv
// Checker of coprocessor handshake and transfer timing at the port pins.
`timescale 1ns/1ps
module cpx_port_chk (
   // Clock and reset
   input wire        aclk,
   input wire        aresetn,
   // Watched pins
   input wire        coproc_instr_strobe_n,
   input wire        coproc_absent_n,
   input wire        coproc_wait_n,
   input wire        memory_request_n,
   input wire        burst_cycle_flag,
   input wire [31:0] cp_address,
   input wire        data_oe
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   sequence s_gone;
      coproc_absent_n && coproc_wait_n && !coproc_instr_strobe_n;
   endsequence
   sequence s_stall;
      !coproc_absent_n && coproc_wait_n;
   endsequence
   AST_DATA_UNDER_STROBE: assert property (
      !memory_request_n |-> !coproc_instr_strobe_n)
      else $error("data cycle without strobe");
   AST_ADDR_STEP: assert property (
      !memory_request_n && $past(!memory_request_n)
      |-> cp_address == $past(cp_address) + 32'h00000004)
      else $error("address did not step one word");
   AST_FIRST_WORD: assert property (
      $fell(memory_request_n) |-> !burst_cycle_flag
      ##1 (burst_cycle_flag || memory_request_n))
      else $error("first word flagged as sequential");
   AST_COMMIT: assert property (
      $fell(memory_request_n) |-> !coproc_absent_n && !coproc_wait_n)
      else $error("transfer without commit");
   AST_REG_STROBE: assert property (
      memory_request_n && burst_cycle_flag |-> !coproc_instr_strobe_n)
      else $error("register cycle without strobe");
   AST_OE_IN_REG: assert property (
      data_oe |-> memory_request_n && burst_cycle_flag)
      else $error("bus driven outside register cycle");
   AST_OE_ONE: assert property (
      data_oe |=> !data_oe)
      else $error("register transfer longer than one cycle");
   AST_END_QUIET: assert property (
      (coproc_absent_n && coproc_wait_n)[*8]
      |-> memory_request_n && !data_oe)
      else $error("transfer continues after end");
   AST_TRAP: assert property (
      s_gone [*4] |-> ##[1:8] coproc_instr_strobe_n)
      else $error("no trap with coprocessor absent");
   AST_STALL: assert property (
      s_stall [*4] |-> memory_request_n && !burst_cycle_flag)
      else $error("transfer while coprocessor busy");
endmodule // cpx_port_chk

bind cpx_port cpx_port_chk i_chk (.aclk(aclk), .aresetn(aresetn),
   .coproc_instr_strobe_n(coproc_instr_strobe_n),
   .coproc_absent_n(coproc_absent_n), .coproc_wait_n(coproc_wait_n),
   .memory_request_n(memory_request_n),
   .burst_cycle_flag(burst_cycle_flag), .cp_address(cp_address),
   .data_oe(data_oe));

// ===== testbench/cpx_coproc.sv
// Behavioural coprocessor with bus control, facing the processor port.
`timescale 1ns/1ps
module cpx_coproc (
   // Clock and reset
   input  wire        aclk,
   input  wire        aresetn,
   // Processor pins
   input  wire        strobe_n,
   input  wire        user_n,
   input  wire        mreq_n,
   input  wire        burst,
   input  wire        data_oe,
   input  wire [31:0] data_out,
   output reg         absent_n,
   output reg         wait_n,
   output reg         dbe,
   output reg  [31:0] data_in,
   // Scenario controls: mode 0 memory or data op, 1 register, 2 stall
   input  wire [31:0] instr,
   input  wire [1:0]  mode,
   input  wire [3:0]  busy_cyc,
   input  wire [4:0]  n_words,
   input  wire [3:0]  dbe_dly,
   input  wire [31:0] rx_word,
   output reg  [31:0] captured
);
   reg  [1:0] ph;
   reg  [4:0] cnt;
   // Bit 5 marks a privileged instruction in this model's own encoding.
   wire       claim = instr[27] && !(instr[5] && !user_n);
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         absent_n <= 1'b1;
         wait_n   <= 1'b1;
         dbe      <= 1'b0;
         data_in  <= 32'h00000000;
         captured <= 32'h00000000;
         ph       <= 2'h0;
         cnt      <= 5'h00;
      end
      else
      begin
         // A released bus toggles so no stale word can pass as valid.
         data_in <= (dbe && instr[20]) ? rx_word : ~data_in;
         if (data_oe)
            captured <= data_out;
         case (ph)
         2'h0: if (!strobe_n && claim)
         begin
            absent_n <= 1'b0;
            cnt      <= {1'b0, busy_cyc};
            ph       <= 2'h1;
         end
         // Nothing is kept from a broken busy period, so retries repeat.
         2'h1: if (strobe_n)
         begin
            absent_n <= 1'b1;
            ph       <= 2'h0;
         end
         else if (cnt != 5'h00)
            cnt <= cnt - 5'h01;
         else if (mode != 2'h2)
         begin
            wait_n <= 1'b0;
            ph     <= 2'h2;
         end
         2'h2: if (strobe_n)
         begin
            absent_n <= 1'b1;
            wait_n   <= 1'b1;
            dbe      <= 1'b0;
            ph       <= 2'h0;
         end
         else if (mode == 2'h0 && !mreq_n)
         begin
            cnt <= cnt + 5'h01;
            if (cnt == n_words - 5'h01)
            begin
               absent_n <= 1'b1;
               wait_n   <= 1'b1;
               ph       <= 2'h3;
            end
         end
         else if (mode == 2'h1 && mreq_n && burst)
         begin
            cnt <= cnt + 5'h01;
            if (cnt >= {1'b0, dbe_dly})
               dbe <= 1'b1;
         end
         default: if (strobe_n)
            ph <= 2'h0;
         endcase
      end
   end
endmodule // cpx_coproc

// ===== testbench/cpx_port_bench.sv
// Register-level regression of the coprocessor port with a model partner.
`timescale 1ns/1ps
`include "cpx_defines.vh"
module cpx_port_bench;
   reg         aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   reg  [7:0]  awaddr, araddr;
   reg  [31:0] wdata, instr, rx_word, v;
   reg  [3:0]  wstrb, busy_cyc, dbe_dly;
   reg  [1:0]  mode, resp;
   reg  [4:0]  n_words;
   reg         strobe_q;
   wire        awready, wready, bvalid, arready, rvalid;
   wire [1:0]  bresp, rresp;
   wire [31:0] rdata, addr, din, dout, captured;
   wire        strobe_n, absent_n, wait_n, user_n, mreq_n, burst, dbe, oe;
   integer     fail_count = 0, n_tests = 0, cycles = 0, falls = 0, f, i;
   reg  [31:0] ins_t [0:4];
   reg  [2:0]  ctl_t [0:4];
   reg  [1:0]  mode_t [0:4];
   reg         und_t [0:4];
   cpx_port i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .coproc_instr_strobe_n(strobe_n), .coproc_absent_n(absent_n),
      .coproc_wait_n(wait_n), .user_mode_indicator_n(user_n),
      .memory_request_n(mreq_n), .burst_cycle_flag(burst),
      .cp_address(addr), .data_bus_enable_in(dbe), .data_in(din),
      .data_out(dout), .data_oe(oe));
   cpx_coproc i_cop (.aclk(aclk), .aresetn(aresetn), .strobe_n(strobe_n),
      .user_n(user_n), .mreq_n(mreq_n), .burst(burst), .data_oe(oe),
      .data_out(dout), .absent_n(absent_n), .wait_n(wait_n), .dbe(dbe),
      .data_in(din), .instr(instr), .mode(mode), .busy_cyc(busy_cyc),
      .n_words(n_words), .dbe_dly(dbe_dly), .rx_word(rx_word),
      .captured(captured));
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   always @(posedge aclk)
   begin
      strobe_q <= strobe_n;
      if (strobe_q === 1'b1 && strobe_n === 1'b0)
         falls <= falls + 1;
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         fail_count = fail_count + 1;
         final_report;
      end
   end
   task chk(input [31:0] got, input [31:0] exp);
   begin
      n_tests = n_tests + 1;
      if (got !== exp)
      begin
         fail_count = fail_count + 1;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   end
   endtask
   // Response readies stay high for the whole run.
   task wr(input [7:0] a, input [31:0] d);
      reg aw, w;
   begin
      aw = 1'b0;
      w = 1'b0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(aw && w))
      begin
         @(posedge aclk);
         if (!aw && awready === 1'b1)
         begin
            aw = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w && wready === 1'b1)
         begin
            w = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      resp = bresp;
   end
   endtask
   task rd(input [7:0] a);
   begin
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      v = rdata;
      resp = rresp;
   end
   endtask
   task wait_done;
      integer k;
   begin
      k = 0;
      do
      begin
         rd(`CPX_OFF_STATUS);
         k = k + 1;
      end
      while (v[5:4] == 2'h0 && k < 100);
   end
   endtask
   task issue(input [31:0] ins, input [31:0] ctrl);
   begin
      instr <= ins;
      wr(`CPX_OFF_INSTR, ins);
      wr(`CPX_OFF_CTRL, ctrl);
   end
   endtask
   task final_report;
   begin
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   end
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      {aresetn, awvalid, wvalid, arvalid, awaddr, araddr} = 0;
      {bready, rready, wstrb, wdata, mode, instr} = {2'h3, 4'hf, 66'h0};
      {busy_cyc, dbe_dly, n_words, rx_word} = {4'h3, 4'h2, 5'h04, 32'h0};
      ins_t[0] = 32'h0c000000; ctl_t[0] = 3'h1; und_t[0] = 1'b0;
      ins_t[1] = 32'h06000000; ctl_t[1] = 3'h3; und_t[1] = 1'b1;
      ins_t[2] = 32'h0e000000; ctl_t[2] = 3'h3; und_t[2] = 1'b0;
      ins_t[3] = 32'h0c000000; ctl_t[3] = 3'h3; und_t[3] = 1'b0;
      ins_t[4] = 32'h0e100030; ctl_t[4] = 3'h7; und_t[4] = 1'b1;
      mode_t[0] = 2'h0; mode_t[1] = 2'h0; mode_t[2] = 2'h0;
      mode_t[3] = 2'h0; mode_t[4] = 2'h1;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      rd(`CPX_OFF_STATUS);
      chk(v, 32'h0);
      rd(8'h20);
      chk({resp, v[7:0]}, {`CPX_RESP_SLVERR, 8'h00});
      wr(`CPX_OFF_STATUS, 32'h1);
      chk(resp, `CPX_RESP_SLVERR);
      wr(`CPX_OFF_ADDR, 32'h100);
      for (i = 0; i < 5; i = i + 1)
      begin
         mode <= mode_t[i];
         f = falls;
         issue(ins_t[i], ctl_t[i]);
         wait_done;
         chk(falls - f, i != 0);
         chk({v[6], v[4]}, und_t[i]);
         if (i == 3)
            chk(v[15:8] >= 8'h04, 1);
      end
      chk(user_n, 0);
      mode <= 2'h2;
      f = falls;
      issue(32'h0c000000, 32'h3);
      repeat (10) @(posedge aclk);
      wr(`CPX_OFF_CTRL, 32'ha);
      repeat (6) @(posedge aclk);
      chk(strobe_n, 1);
      rd(`CPX_OFF_STATUS);
      chk(v[6], 1);
      mode <= 2'h0;
      wr(`CPX_OFF_CTRL, 32'h2);
      wait_done;
      chk(v[4], 0);
      chk(falls - f, 2);
      chk(user_n, 1);
      n_words <= 5'h10;
      issue(32'h0c000000, 32'h3);
      repeat (10) @(posedge aclk);
      wr(`CPX_OFF_CTRL, 32'ha);
      wait_done;
      chk(v[6:4], 3'h2);
      wr(`CPX_OFF_CTRL, 32'h2);
      mode <= 2'h1;
      for (i = 0; i < 3; i = i + 1)
      begin
         rx_word <= 32'h5a5a0000 + i;
         issue(32'h0e100010, 32'h3);
         if (i < 2)
            wait_done;
      end
      repeat (20) @(posedge aclk);
      rd(`CPX_OFF_STATUS);
      chk(v[5:3], 3'h1);
      for (i = 0; i < 4; i = i + 1)
      begin
         rd(`CPX_OFF_RXDATA);
         chk(v, i < 3 ? 32'h5a5a0000 + i : 32'h0);
         if (i == 0)
            wait_done;
      end
      dbe_dly <= 4'h6;
      wr(`CPX_OFF_TXDATA, 32'hc3c30f0f);
      issue(32'h0e000010, 32'h3);
      wait_done;
      chk(captured, 32'hc3c30f0f);
      final_report;
   end
endmodule // cpx_port_bench
